// ==== rtl/scrb_pkg.sv ====
/*
 * Constants, field layouts and carrier types for the sensor configuration register bank.
 * Assumes a 200 MHz clock and a telegram decoder outside that delivers checked command words.
 */
`default_nettype none
package scrb_pkg;
    localparam int unsigned CLK_MHZ   = 200;
    localparam int unsigned T_PROG_MS = 100;
    localparam int unsigned PROG_CYC  = T_PROG_MS * CLK_MHZ * 1000;
    localparam int unsigned CNT_W     = 25;

    localparam int unsigned CMD_W = 3;
    localparam int unsigned ADR_W = 4;
    localparam int unsigned DAT_W = 14;
    localparam int unsigned CRV_W = 9;
    localparam int unsigned CRV_N = 32;

    typedef enum logic [CMD_W-1:0] {
        CMD_READ  = 3'h0, CMD_WRITEL = 3'h1, CMD_WRITEH = 3'h2, CMD_WRITE = 3'h3,
        CMD_PROG  = 3'h4, CMD_ERASE  = 3'h5, CMD_READL  = 3'h6, CMD_READH = 3'h7
    } scrb_cmd_e;

    localparam logic [ADR_W-1:0] ADR_DRIVE  = 4'h1;
    localparam logic [ADR_W-1:0] ADR_SERIAL = 4'h2;
    localparam logic [ADR_W-1:0] ADR_OFFSET = 4'h3;
    localparam logic [ADR_W-1:0] ADR_GAIN   = 4'h4;
    localparam logic [ADR_W-1:0] ADR_CFG    = 4'h5;
    localparam logic [ADR_W-1:0] ADR_PROT   = 4'h6;
    localparam logic [ADR_W-1:0] ADR_VALUE  = 4'h7;
    localparam logic [ADR_W-1:0] ADR_TRIM   = 4'h8;
    localparam logic [ADR_W-1:0] ADR_AUX    = 4'h9;
    localparam logic [ADR_W-1:0] ADR_TCL    = 4'hB;
    localparam logic [ADR_W-1:0] ADR_TCQ    = 4'hC;

    localparam int unsigned DRV_W = 10;
    localparam int unsigned SER_W = 11;
    localparam int unsigned OFS_W = 11;
    localparam int unsigned GAN_W = 14;
    localparam int unsigned CFG_W = 14;
    localparam int unsigned VAL_W = 12;
    localparam int unsigned TRM_W = 5;
    localparam int unsigned AUX_W = 6;
    localparam int unsigned TCL_W = 7;
    localparam int unsigned TCQ_W = 5;

    // Sub-field positions inside the packed words
    localparam int unsigned DRV_SLEW_LSB = 8;
    localparam int unsigned DRV_LOW_LSB  = 3;
    localparam int unsigned CFG_PER_LSB  = 9;
    localparam int unsigned CFG_FMT_LSB  = 6;
    localparam int unsigned CFG_FIL_LSB  = 3;
    localparam int unsigned AUX_SEN_LSB  = 4;
    localparam int unsigned TRM_EN_BIT   = 4;
    localparam int unsigned TCL_MAG_W    = 6;

    typedef struct packed {
        logic [DRV_W-1:0] drive_setup;
        logic [SER_W-1:0] device_serial;
        logic [OFS_W-1:0] output_offset;
        logic [GAN_W-1:0] output_gain;
        logic [CFG_W-1:0] config_word;
        logic             protection_latch;
        logic [TRM_W-1:0] offset_trim;
        logic [AUX_W-1:0] aux_config;
        logic [TCL_W-1:0] temp_coef_linear;
        logic [TCQ_W-1:0] temp_coef_quadratic;
    } scrb_regs_s;

    typedef struct packed {
        logic [1:0] slew_rate;
        logic [4:0] low_current;
        logic [2:0] high_current;
        logic [4:0] period;
        logic [2:0] out_format;
        logic [2:0] filter;
        logic [2:0] mag_range;
        logic       serial_active;
        logic [3:0] bit_time;
        logic       trim_enable;
        logic [3:0] trim_value;
        logic [5:0] tc_linear;
    } scrb_fields_s;

    typedef struct packed {
        logic             ack;
        logic             parity;
        logic [DAT_W-1:0] data;
    } scrb_rsp_s;

    typedef logic [CRV_N-1:0][CRV_W-1:0] scrb_curve_t;
    typedef enum logic [1:0] {ST_LOAD = 2'h0, ST_IDLE = 2'h1, ST_ERASE = 2'h3, ST_PROG = 2'h2} scrb_state_e;
endpackage
`default_nettype wire

// ==== rtl/scrb_bank.sv ====
/*
 * Register bank of a programmable sensor: working RAM copy, nonvolatile copy, lock and readout.
 * Assumes an outside telegram decoder that presents one checked command per cmd_valid pulse
 * and turns rsp_* into the acknowledge and read telegram. rst models power-up.
 */
// Overview of operation
// RULE1: Drive setup register, 10 bits unsigned, at address 1.
// RULE2: Serial number, 11 bits, address 2, used only in biphase output mode.
// RULE3: Output offset, 11-bit two's complement, at address 3.
// RULE4: Output gain, 14-bit sign and magnitude, at address 4.
// RULE5: Config word at 5: period*512 + format*64 + filter*8 + range.
// RULE6: Write-only protection latch at 6, effective after next power-up.
// RULE7: Read-only 12-bit processed value at address 7.
// RULE8: Offset trim at 8: four low bits two's complement, top bit enables.
// RULE9: Aux config at 9: serial enable*16 plus biphase bit time.
// RULE10: Drive setup packs slew*256 + low current*8 + high current.
// RULE11: Linear temperature coefficient at 11, 7 bits, top bit ignored.
// RULE12: Quadratic temperature coefficient at 12, 5 bits unsigned.
// RULE13: Thirty-two 9-bit setpoints in low and high banks of sixteen.
// RULE14: Writes touch only RAM; reads return the stored nonvolatile copy.
// RULE15: Programmer stores by erase, then program, then read.
// RULE16: Erase and program act on all registers, address ignored.
// RULE17: Programmer may batch writes then issue one erase and program.
// RULE18: Programmer checks acknowledge and parity of every exchange.
// RULE19: Programmer sets the latch last and reads back to confirm.
// RULE20: Write data uses trailing bits, read data leading bits.
// RULE21: Erase command code is 5, program command code is 4.
// RULE22: With protection active, writes, erase and program are ignored.
`default_nettype none
module scrb_bank
    import scrb_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              nv_blank,
    input  wire logic              cmd_valid,
    input  wire logic [CMD_W-1:0]  cmd_code,
    input  wire logic [ADR_W-1:0]  cmd_addr,
    input  wire logic [DAT_W-1:0]  cmd_data,
    input  wire logic [VAL_W-1:0]  sample_value,
    output var  logic              rsp_valid,
    output var  scrb_rsp_s         rsp,
    output var  logic              busy,
    output var  logic              lock_active,
    output var  scrb_regs_s        settings,
    output var  scrb_fields_s      fields,
    output var  scrb_curve_t       curve_points
);
    scrb_state_e      state_ff;
    scrb_regs_s       ram_ff;
    scrb_regs_s       nv_ff;
    scrb_curve_t      ram_curve_ff;
    scrb_curve_t      nv_curve_ff;
    logic [CNT_W-1:0] prog_cnt_ff;
    logic             lock_ff;
    logic             rsp_valid_ff;
    scrb_rsp_s        rsp_ff;
    scrb_fields_s     fields_ff;
    logic             busy_ff;

    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);

    scrb_cmd_e  cmd;
    logic       idle;
    logic       is_write;
    logic       is_store;
    logic       accept;
    logic       prog_done;
    logic [4:0] crv_idx;
    logic [DAT_W-1:0] nxt_rd_data;

    assign cmd       = scrb_cmd_e'(cmd_code);
    assign idle      = (state_ff == ST_IDLE);
    assign is_write  = (cmd == CMD_WRITE) || (cmd == CMD_WRITEL) || (cmd == CMD_WRITEH);
    assign is_store  = (cmd == CMD_ERASE) || (cmd == CMD_PROG);
    // Locked parts still answer reads so the programmer can confirm the lock
    assign accept    = cmd_valid && idle && !(lock_ff && (is_write || is_store)); // RULE22
    assign prog_done = (prog_cnt_ff == PROG_LAST);
    assign crv_idx   = {cmd == CMD_WRITEH || cmd == CMD_READH, cmd_addr}; // RULE13

    // Power-up loads RAM from the nonvolatile copy; also samples the latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_LOAD;
        end else begin
            case (state_ff)
                ST_LOAD: state_ff <= ST_IDLE;
                ST_IDLE: begin
                    if (accept && cmd == CMD_ERASE) begin // RULE21
                        state_ff <= ST_ERASE;
                    end else if (accept && cmd == CMD_PROG) begin // RULE21
                        state_ff <= ST_PROG;
                    end
                end
                ST_ERASE, ST_PROG: begin
                    if (prog_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_cnt_ff <= '0;
        end else if (state_ff == ST_ERASE || state_ff == ST_PROG) begin
            prog_cnt_ff <= prog_done ? '0 : prog_cnt_ff + 1'b1;
        end else begin
            prog_cnt_ff <= '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff == ST_ERASE || state_ff == ST_PROG) ? !prog_done
                     : (accept && is_store);
        end
    end

    // Lock takes effect only from the copy found at power-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (state_ff == ST_LOAD) begin
            lock_ff <= nv_ff.protection_latch; // RULE6
        end
    end

    // Nonvolatile copy has no reset: it survives power cycles. nv_blank models a virgin part.
    // Erase clears every cell; program can only set bits, hence erase must come first.
    always_ff @(posedge clk) begin
        if (nv_blank) begin
            nv_ff       <= '0;
            nv_curve_ff <= '0;
        end else if (state_ff == ST_ERASE && prog_done) begin // RULE16
            nv_ff       <= '0;
            nv_curve_ff <= '0;
        end else if (state_ff == ST_PROG && prog_done) begin // RULE16
            nv_ff       <= nv_ff | ram_ff;
            nv_curve_ff <= nv_curve_ff | ram_curve_ff;
        end
    end

    // Working RAM copy; writes take the trailing bits of the data field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_ff <= '0;
        end else if (state_ff == ST_LOAD) begin
            ram_ff <= nv_ff;
        end else if (accept && cmd == CMD_WRITE) begin // RULE14
            case (cmd_addr)
                ADR_DRIVE:  ram_ff.drive_setup         <= cmd_data[DRV_W-1:0]; // RULE1 RULE20
                ADR_SERIAL: ram_ff.device_serial       <= cmd_data[SER_W-1:0]; // RULE2
                ADR_OFFSET: ram_ff.output_offset       <= cmd_data[OFS_W-1:0]; // RULE3
                ADR_GAIN:   ram_ff.output_gain         <= cmd_data[GAN_W-1:0]; // RULE4
                ADR_CFG:    ram_ff.config_word         <= cmd_data[CFG_W-1:0]; // RULE5
                ADR_PROT:   ram_ff.protection_latch    <= cmd_data[0]; // RULE6
                ADR_TRIM:   ram_ff.offset_trim         <= cmd_data[TRM_W-1:0]; // RULE8
                ADR_AUX:    ram_ff.aux_config          <= cmd_data[AUX_W-1:0]; // RULE9
                ADR_TCL:    ram_ff.temp_coef_linear    <= cmd_data[TCL_W-1:0]; // RULE11
                ADR_TCQ:    ram_ff.temp_coef_quadratic <= cmd_data[TCQ_W-1:0]; // RULE12
                default:    ram_ff <= ram_ff; // Readout and unmapped addresses absorb writes
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_curve_ff <= '0;
        end else if (state_ff == ST_LOAD) begin
            ram_curve_ff <= nv_curve_ff;
        end else if (accept && (cmd == CMD_WRITEL || cmd == CMD_WRITEH)) begin
            ram_curve_ff[crv_idx] <= cmd_data[CRV_W-1:0]; // RULE13 RULE14
        end
    end

    // Reads come from the stored copy, the readout from sample_value, left-justified in the data field
    always_comb begin
        nxt_rd_data = '0;
        if (cmd == CMD_READL || cmd == CMD_READH) begin
            nxt_rd_data = {nv_curve_ff[crv_idx], {(DAT_W-CRV_W){1'b0}}}; // RULE13 RULE20
        end else begin
            case (cmd_addr)
                ADR_DRIVE:  nxt_rd_data = {nv_ff.drive_setup, {(DAT_W-DRV_W){1'b0}}}; // RULE14 RULE20
                ADR_SERIAL: nxt_rd_data = {nv_ff.device_serial, {(DAT_W-SER_W){1'b0}}};
                ADR_OFFSET: nxt_rd_data = {nv_ff.output_offset, {(DAT_W-OFS_W){1'b0}}};
                ADR_GAIN:   nxt_rd_data = nv_ff.output_gain;
                ADR_CFG:    nxt_rd_data = nv_ff.config_word;
                ADR_VALUE:  nxt_rd_data = {sample_value, {(DAT_W-VAL_W){1'b0}}}; // RULE7
                ADR_TRIM:   nxt_rd_data = {nv_ff.offset_trim, {(DAT_W-TRM_W){1'b0}}};
                ADR_AUX:    nxt_rd_data = {nv_ff.aux_config, {(DAT_W-AUX_W){1'b0}}};
                ADR_TCL:    nxt_rd_data = {nv_ff.temp_coef_linear, {(DAT_W-TCL_W){1'b0}}};
                ADR_TCQ:    nxt_rd_data = {nv_ff.temp_coef_quadratic, {(DAT_W-TCQ_W){1'b0}}};
                default:    nxt_rd_data = '0; // Latch is write-only; unmapped reads zero
            endcase
        end
    end

    // One answer per command: immediate for reads, writes and refused stores, at the end for accepted erase and program
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff       <= '0;
        end else begin
            rsp_valid_ff <= (cmd_valid && !(idle && accept && is_store))
                         || ((state_ff == ST_ERASE || state_ff == ST_PROG) && prog_done);
            if ((state_ff == ST_ERASE || state_ff == ST_PROG) && prog_done) begin
                rsp_ff <= '{ack: 1'b1, parity: 1'b1, data: '0};
            end else if (cmd_valid && accept && is_store) begin
                rsp_ff <= rsp_ff; // A store answers at its end; the last answer stands until then
            end else if (cmd_valid && accept && !is_write) begin
                rsp_ff <= '{ack: 1'b1, parity: ~^nxt_rd_data, data: nxt_rd_data};
            end else if (cmd_valid) begin
                rsp_ff <= '{ack: accept, parity: 1'b1, data: '0};
            end
        end
    end

    // Decoded settings for the analog and output stages, from the working copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fields_ff <= '0;
        end else begin
            fields_ff.slew_rate     <= ram_ff.drive_setup[DRV_W-1:DRV_SLEW_LSB]; // RULE10
            fields_ff.low_current   <= ram_ff.drive_setup[DRV_SLEW_LSB-1:DRV_LOW_LSB]; // RULE10
            fields_ff.high_current  <= ram_ff.drive_setup[DRV_LOW_LSB-1:0]; // RULE10
            fields_ff.period        <= ram_ff.config_word[CFG_W-1:CFG_PER_LSB]; // RULE5
            fields_ff.out_format    <= ram_ff.config_word[CFG_PER_LSB-1:CFG_FMT_LSB]; // RULE5
            fields_ff.filter        <= ram_ff.config_word[CFG_FMT_LSB-1:CFG_FIL_LSB]; // RULE5
            fields_ff.mag_range     <= ram_ff.config_word[CFG_FIL_LSB-1:0]; // RULE5
            fields_ff.serial_active <= |ram_ff.aux_config[AUX_W-1:AUX_SEN_LSB]; // RULE2 RULE9
            fields_ff.bit_time      <= ram_ff.aux_config[AUX_SEN_LSB-1:0]; // RULE9
            fields_ff.trim_enable   <= ram_ff.offset_trim[TRM_EN_BIT]; // RULE8
            fields_ff.trim_value    <= ram_ff.offset_trim[TRM_EN_BIT-1:0]; // RULE8
            fields_ff.tc_linear     <= ram_ff.temp_coef_linear[TCL_MAG_W-1:0]; // RULE11
        end
    end

    assign rsp_valid    = rsp_valid_ff;
    assign rsp          = rsp_ff;
    assign busy         = busy_ff;
    assign lock_active  = lock_ff;
    assign settings     = ram_ff;
    assign fields       = fields_ff;
    assign curve_points = ram_curve_ff;

    a_write_ram_only: assert property (@(posedge clk) disable iff (rst) // RULE14
        accept && cmd == CMD_WRITE && cmd_addr == ADR_GAIN
        |=> ram_ff.output_gain == $past(cmd_data) && $stable(nv_ff))
        else $error("gain write did not land in RAM only");

    a_lock_blocks_write: assert property (@(posedge clk) disable iff (rst) // RULE22
        lock_ff && cmd_valid && (is_write || is_store)
        |=> $stable(ram_ff) && !busy_ff && rsp_valid_ff && !rsp_ff.ack)
        else $error("locked part accepted a write or store");

    a_erase_clears_all: assert property (@(posedge clk) disable iff (rst || nv_blank) // RULE16
        state_ff == ST_ERASE && prog_done |=> nv_ff == '0 && nv_curve_ff == '0)
        else $error("erase left a stored bit set");

    a_store_code_busy: assert property (@(posedge clk) disable iff (rst) // RULE21
        accept && cmd_code == 3'h4 |=> state_ff == ST_PROG && busy_ff ##1 busy_ff || rsp_valid_ff)
        else $error("program code did not start a store");

    a_read_leading_bits: assert property (@(posedge clk) disable iff (rst) // RULE20
        accept && cmd == CMD_READ && cmd_addr == ADR_TCQ
        |=> rsp_ff.data[DAT_W-TCQ_W-1:0] == '0 && rsp_ff.data[DAT_W-1:DAT_W-TCQ_W] == $past(nv_ff.temp_coef_quadratic))
        else $error("read data not left-justified");

    a_readout_capture: assert property (@(posedge clk) disable iff (rst) // RULE7
        accept && cmd == CMD_READ && cmd_addr == ADR_VALUE
        |=> rsp_valid_ff && rsp_ff.ack && rsp_ff.data[DAT_W-1:DAT_W-VAL_W] == $past(sample_value))
        else $error("readout value not returned");

    a_curve_points_high_bank: assert property (@(posedge clk) disable iff (rst) // RULE13
        accept && cmd == CMD_WRITEH |=> ram_curve_ff[{1'b1, $past(cmd_addr)}] == $past(cmd_data[CRV_W-1:0]))
        else $error("high bank setpoint misplaced");

    a_drive_fields_split: assert property (@(posedge clk) disable iff (rst) // RULE10
        ##1 {fields_ff.slew_rate, fields_ff.low_current, fields_ff.high_current} == $past(ram_ff.drive_setup))
        else $error("drive setup fields split wrongly");

    a_lock_from_power_up: assert property (@(posedge clk) disable iff (rst) // RULE6
        state_ff != ST_LOAD |-> $stable(lock_ff) || $past(state_ff) == ST_LOAD)
        else $error("lock changed without power-up");
endmodule
`default_nettype wire

// ==== bench/scrb_prog_model.sv ====
/*
 * Programmer model: sends one checked command word per transfer and checks each answer.
 * Assumes the register bank on the same clock; its inputs change at the falling edge.
 */
`default_nettype none
module scrb_prog_model
    import scrb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rsp_valid,
    input  wire scrb_rsp_s        rsp,
    output var  logic             cmd_valid,
    output var  logic [CMD_W-1:0] cmd_code,
    output var  logic [ADR_W-1:0] cmd_addr,
    output var  logic [DAT_W-1:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_addr  = 4'h0;
        cmd_data  = 14'h0;
    end

    // Bounded wait covers the longest store; a missing answer leaves ok low
    task automatic send(input logic [2:0] code, input logic [3:0] addr, input logic [13:0] data,
                        output scrb_rsp_s ans, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_addr  = addr;
        cmd_data  = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_addr  = ~addr;
        cmd_data  = ~data;
        while (rsp_valid !== 1'b1 && n < 64) begin
            @(posedge clk);
            #1;
            n++;
        end
        ans = rsp;
        ok  = (rsp_valid === 1'b1) && (rsp.ack === 1'b1) && (rsp.parity === ~^rsp.data);
    endtask

    // Several writes may share one store, so a store is only erase then program
    task automatic store(input logic [3:0] addr, output logic ok);
        scrb_rsp_s a;
        logic      e;
        send(3'h5, addr, 14'h0, a, e);
        send(3'h4, ~addr, 14'h0, a, ok);
        ok = ok & e;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench for the sensor register bank.
 * Assumes scrb_pkg and the programmer model; the store time is shortened to 16 cycles.
 */
`default_nettype none
module tb
    import scrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WID [16] = '{1, 10, 11, 11, 14, 14, 1, 12, 5, 6, 1, 7, 5, 1, 1, 1};
    localparam logic [3:0] RW [11] = '{ADR_DRIVE, ADR_SERIAL, ADR_OFFSET, ADR_GAIN, ADR_CFG, ADR_PROT,
                                       ADR_VALUE, ADR_TRIM, ADR_AUX, ADR_TCL, ADR_TCQ};
    logic             clk, rst, nv_blank, cmd_valid, rsp_valid, busy, lock_active, ok;
    logic [2:0]       cmd_code;
    logic [3:0]       cmd_addr, ad, ix;
    logic [13:0]      cmd_data, d;
    logic [11:0]      sample_value;
    scrb_rsp_s        rsp, ans;
    scrb_regs_s       settings;
    scrb_fields_s     fields;
    scrb_curve_t      curve_points;
    logic [13:0]      ram_img [16];
    logic [13:0]      nv_img [16];
    logic [8:0]       crv_ram [32];
    logic [8:0]       crv_nv [32];
    int               miscompares, n_tests;
    scrb_regs_s       exp_regs;
    scrb_fields_s     exp_fields;
    logic [13:0]      exp_data;

    scrb_bank #(.PROG_CYCLES(16)) uut (.clk(clk), .rst(rst), .nv_blank(nv_blank), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .sample_value(sample_value),
        .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .lock_active(lock_active), .settings(settings),
        .fields(fields), .curve_points(curve_points));
    scrb_prog_model u_prog (.clk(clk), .rsp_valid(rsp_valid), .rsp(rsp), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [13:0] lj(input logic [13:0] v, input int w);
        return v << (14 - w);
    endfunction

    // Expected working copy, packed in the order of the settings port
    task automatic check_ram();
        exp_regs = {ram_img[1][9:0], ram_img[2][10:0], ram_img[3][10:0], ram_img[4], ram_img[5],
                    ram_img[6][0], ram_img[8][4:0], ram_img[9][5:0], ram_img[11][6:0], ram_img[12][4:0]};
        check("settings", settings, exp_regs);
    endtask

    task automatic store_all();
        fork
            u_prog.store(4'($urandom), ok);
            begin
                // One edge after the erase is taken the store must already show busy
                repeat (3) @(posedge clk);
                #1;
                check("busy_in_store", busy, 1'b1);
            end
        join
        check("store_ack", ok, 1'b1);
        check("busy_after_store", busy, 1'b0);
        nv_img = ram_img;
        crv_nv = crv_ram;
    endtask

    // Watchdog: the whole run needs a few hundred cycles, this allows some 40,000
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial begin
        miscompares = 0;
        n_tests = 0;
        rst = 1'b1;
        nv_blank = 1'b1;
        sample_value = 12'h0;
        foreach (ram_img[i]) ram_img[i] = 14'h0;
        foreach (crv_ram[i]) crv_ram[i] = 9'h0;
        nv_img = ram_img;
        crv_nv = crv_ram;
        void'($urandom(99841));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        nv_blank = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_ram();
        $display("test blank power-up done");
        // Round 0 writes all ones with junk above each field, round 1 random words
        for (int r = 0; r < 2; r++) begin
            foreach (RW[k]) begin
                ad = RW[k];
                d = (r == 0) ? 14'h3FFF : 14'($urandom);
                u_prog.send(CMD_WRITE, ad, d, ans, ok);
                check("write_ack", ok, 1'b1);
                if (ad != ADR_VALUE) ram_img[ad] = d & ~(14'h3FFF << WID[ad]);
                check_ram();
                u_prog.send(CMD_READ, ad, ~d, ans, ok);
                if (ad < ADR_VALUE) check("read_before_store", ans.data, lj(nv_img[ad], WID[ad]));
            end
            ix = 4'($urandom);
            d = 14'($urandom);
            u_prog.send(CMD_WRITEL, ix, d, ans, ok);
            crv_ram[ix] = d[8:0];
            u_prog.send(CMD_WRITEH, ix, ~d, ans, ok);
            crv_ram[16 + ix] = ~d[8:0];
            check("curve_points_low", curve_points[ix], crv_ram[ix]);
            check("curve_points_high", curve_points[16 + ix], crv_ram[16 + ix]);
            @(posedge clk);
            #1;
            exp_fields = {ram_img[1][9:8], ram_img[1][7:3], ram_img[1][2:0], ram_img[5][13:9], ram_img[5][8:6],
                          ram_img[5][5:3], ram_img[5][2:0], |ram_img[9][5:4], ram_img[9][3:0], ram_img[8][4],
                          ram_img[8][3:0], ram_img[11][5:0]};
            check("fields", fields, exp_fields);
            ram_img[6] = 14'h0;
            u_prog.send(CMD_WRITE, ADR_PROT, 14'h0, ans, ok);
            store_all();
            foreach (RW[k]) begin
                ad = RW[k];
                @(negedge clk);
                sample_value = 12'($urandom);
                u_prog.send(CMD_READ, ad, 14'($urandom), ans, ok);
                check("read_ok", ok, 1'b1);
                exp_data = (ad == ADR_VALUE) ? lj({2'h0, sample_value}, 12) :
                           (ad == ADR_PROT) ? 14'h0 : lj(nv_img[ad], WID[ad]);
                check("read_stored", ans.data, exp_data);
            end
            u_prog.send(CMD_READL, ix, 14'h0, ans, ok);
            check("curve_points_low_read", ans.data, lj({5'h0, crv_nv[ix]}, 9));
            u_prog.send(CMD_READH, ix, 14'h0, ans, ok);
            check("curve_points_high_read", ans.data, lj({5'h0, crv_nv[16 + ix]}, 9));
            $display("test round %0d done", r);
        end
        u_prog.send(CMD_WRITE, ADR_PROT, 14'h1, ans, ok);
        ram_img[6] = 14'h1;
        store_all();
        check("lock_early", lock_active, 1'b0);
        d = 14'($urandom);
        u_prog.send(CMD_WRITE, ADR_GAIN, d, ans, ok);
        check("gain_unlocked", settings.output_gain, d);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("lock_after_power_up", lock_active, 1'b1);
        check("gain_reloaded", settings.output_gain, nv_img[ADR_GAIN]);
        u_prog.send(CMD_WRITE, ADR_GAIN, ~d, ans, ok);
        check("locked_write_ack", ans.ack, 1'b0);
        u_prog.send(CMD_ERASE, ADR_GAIN, 14'h0, ans, ok);
        check("locked_erase_ack", ans.ack, 1'b0);
        u_prog.send(CMD_READ, ADR_GAIN, 14'h0, ans, ok);
        check("locked_read", ans.data, nv_img[ADR_GAIN]);
        check("locked_ram", settings.output_gain, nv_img[ADR_GAIN]);
        $display("test lock done");
        wrap_up();
    end
endmodule
`default_nettype wire
